/* File: dv/sts_seq_asserts.sv */
module sts_seq_asserts #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register bus
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // sequencer
  input wire logic second_stage_event_i,
  input wire logic trigger_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // both write channels taken while no response is pending
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      && !s_axi_bvalid_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && !s_axi_rvalid_o;
  endsequence
  chk_trig_pulse: assert property (trigger_o |=> !trigger_o)
    else $error("trigger wider than one cycle");
  // sync latency plus the registered pulse gives three to five cycles
  chk_trig_cause: assert property ($rose(trigger_o) |->
    $past(second_stage_event_i, 3) || $past(second_stage_event_i, 4)
      || $past(second_stage_event_i, 5))
    else $error("trigger without second stage event");
  chk_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid_o)
    else $error("write answer late");
  chk_unmapped_err: assert property (s_rd_take ##0 (s_axi_araddr_i > 8'h1b)
    |=> s_axi_rresp_o == sts_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_write_okay: assert property (s_wr_take ##0 (s_axi_awaddr_i <= 8'h14)
    |-> ##[1:2] s_axi_bvalid_o && s_axi_bresp_o == sts_pkg::RESP_OKAY)
    else $error("mapped write refused");
endmodule : sts_seq_asserts

/* File: dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // far above the longest expected run
  localparam int LIMIT = 5000;
  logic clk_i, resetn_i, awv, wv, bready, arv, rready, ev1, ev2;
  logic awready, wready, bvalid, arready, rvalid, ltwo, rtwo, trig;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, modes;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] chan;
  int failures, check_count, cycles, trig_seen, exp_trig, seed, m;

  sts_sequencer sts_sequencer_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .first_stage_event_i(ev1), .second_stage_event_i(ev2),
    .chan_level_i(chan), .long_timer_stage_two_o(ltwo),
    .range_qual_stage_two_o(rtwo), .trigger_o(trig));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // model side: count triggers seen, cut a hang short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (resetn_i && trig === 1'b1) trig_seen <= trig_seen + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // handshakes judged at the falling edge, where nothing moves
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_i);
      ta = ta || (awv && awready);
      tw = tw || (wv && wready);
      @(posedge clk_i);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    do @(negedge clk_i); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge clk_i);
    bready <= 1'b0;
    // let an edge pass so a following call never re-drives in this step
    @(posedge clk_i);
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk_i); while (!(arv && arready));
    @(posedge clk_i);
    arv <= 1'b0;
    do @(negedge clk_i); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    @(posedge clk_i);
    rready <= 1'b0;
    @(posedge clk_i);
  endtask : rdr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] mask);
    rdr(a);
    chk(rd & mask, e);
  endtask : rchk

  // events held two cycles so the synchroniser cannot miss them
  task automatic pulse(input int which);
    if (which == 1) ev1 <= 1'b1;
    else ev2 <= 1'b1;
    repeat (2) @(posedge clk_i);
    ev1 <= 1'b0;
    ev2 <= 1'b0;
  endtask : pulse

  task automatic summarize();
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    {awv, wv, bready, arv, rready, ev1, ev2} = 7'h0;
    {awaddr, araddr, wdata, chan} = 52'h0;
    {failures, check_count, cycles, trig_seen, exp_trig} = '0;
    seed = 97529;
    resetn_i = 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    // every register clears on reset
    for (m = 0; m < 7; m++) rchk(8'(m * 4), sts_pkg::RST_ZERO, '1);
    // every mode on both stages, then an illegal code
    for (m = 0; m < 9; m++) begin
      modes = {20'h0, 4'(8 - m), 4'h0, 4'(m)};
      wr(sts_pkg::OFF_MODE, modes);
      rchk(sts_pkg::OFF_MODE, modes, 32'h0f0f);
    end
    wr(sts_pkg::OFF_MODE, 32'h0909);
    rchk(sts_pkg::OFF_MODE, modes, 32'h0f0f);
    m = $random(seed);
    wr(sts_pkg::OFF_RTIME, 32'(m));
    rchk(sts_pkg::OFF_RTIME, 32'(m), '1);
    m = $random(seed);
    wr(sts_pkg::OFF_DTIME, 32'(m));
    rchk(sts_pkg::OFF_DTIME, 32'(m), '1);
    // unmapped place is refused both ways
    wr(8'h40, 32'h1);
    chk({30'h0, rs}, {30'h0, sts_pkg::RESP_SLVERR});
    rchk(8'h40, 32'h0, '1);
    chk({30'h0, rs}, {30'h0, sts_pkg::RESP_SLVERR});
    wr(sts_pkg::OFF_CTRL, 32'h7);
    rchk(sts_pkg::OFF_CTRL, 32'h7, 32'h7);
    // pattern reset strips AND; stage one keeps shared resources
    wr(sts_pkg::OFF_CTRL, 32'h3);
    wr(sts_pkg::OFF_DET, 32'h3f);
    rchk(sts_pkg::OFF_DET, 32'h14, 32'h3f);
    chk({30'h0, ltwo, rtwo}, 32'h0);
    wr(sts_pkg::OFF_CTRL, 32'h0);
    wr(sts_pkg::OFF_DET, 32'h2b);
    rchk(sts_pkg::OFF_DET, 32'h2b, 32'h3f);
    chk({30'h0, ltwo, rtwo}, 32'h3);
    // time reset alone strips only the stage one AND
    wr(sts_pkg::OFF_CTRL, 32'h1);
    wr(sts_pkg::OFF_DET, 32'h3);
    rchk(sts_pkg::OFF_DET, 32'h2, 32'h3f);
    wr(sts_pkg::OFF_CTRL, 32'h0);
    // reset off: waits in second stage search for a long time
    pulse(1);
    repeat (60) @(posedge clk_i);
    rchk(sts_pkg::OFF_STAT, 32'h2, 32'h3);
    pulse(2);
    repeat (8) @(posedge clk_i);
    exp_trig++;
    chk(trig_seen, exp_trig);
    rchk(sts_pkg::OFF_STAT, 32'h0, 32'h3);
    // delay: second stage event ignored until it runs out
    wr(sts_pkg::OFF_DTIME, 32'd40);
    wr(sts_pkg::OFF_CTRL, 32'h4);
    pulse(1);
    repeat (4) @(posedge clk_i);
    rchk(sts_pkg::OFF_STAT, 32'h1, 32'h3);
    pulse(2);
    repeat (4) @(posedge clk_i);
    chk(trig_seen, exp_trig);
    repeat (40) @(posedge clk_i);
    rchk(sts_pkg::OFF_STAT, 32'h2, 32'h3);
    pulse(2);
    repeat (8) @(posedge clk_i);
    exp_trig++;
    chk(trig_seen, exp_trig);
    // time reset counts only once the delay is over
    wr(sts_pkg::OFF_DTIME, 32'd30);
    wr(sts_pkg::OFF_RTIME, 32'd30);
    wr(sts_pkg::OFF_CTRL, 32'h5);
    pulse(1);
    repeat (40) @(posedge clk_i);
    rchk(sts_pkg::OFF_STAT, 32'h2, 32'h3);
    repeat (30) @(posedge clk_i);
    rchk(sts_pkg::OFF_STAT, 32'h10, 32'h33);
    chk(trig_seen, exp_trig);
    // pattern reset hits while the delay still runs
    wr(sts_pkg::OFF_PAT, {30'h0, sts_pkg::PAT_HIGH});
    chan <= 4'($random(seed)) & 4'he;
    wr(sts_pkg::OFF_DTIME, 32'd200);
    wr(sts_pkg::OFF_CTRL, 32'h7);
    pulse(1);
    repeat (4) @(posedge clk_i);
    chan <= 4'($random(seed)) | 4'h1;
    repeat (6) @(posedge clk_i);
    rchk(sts_pkg::OFF_STAT, 32'h20, 32'h33);
    chk(trig_seen, exp_trig);
    summarize();
  end
endmodule : testbench

bind sts_sequencer sts_seq_asserts #(.NCH(NCH)) sts_seq_asserts_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .trigger_o(trigger_o),
  .second_stage_event_i(second_stage_event_i));

/* File: inc/sts_pkg.sv */
// Behaviour
// - first stage mode register, nine modes, readable
// - second stage mode register, independent, readable
// - no edge-then-edge or video modes
// - pattern reset forbids stage AND qualifier
// - range qualifier on one stage only
// - one long timer over 30 ns
// - alternating edge mode not selectable
// - device assigns long timer and range qualifier
// - reset enable bit, readable
// - time reset aborts without trigger
// - reset timer starts after delay ends
// - pattern reset aborts without trigger
// - pattern match starts right after stage one
// - reset enabled forbids stage one AND
// - reset type select time or pattern
// - per channel pattern high low dont care
// - reset duration stored and readable
// - delay enable bit, readable
// - delay after stage one before search
// - delay duration stored and readable
// - detector settings carry stage index
package sts_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_PAT = 8'h08;
  localparam logic [7:0] OFF_RTIME = 8'h0c;
  localparam logic [7:0] OFF_DTIME = 8'h10;
  localparam logic [7:0] OFF_DET = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  // mode register fields
  localparam int MODE1_LSB = 0;
  localparam int MODE2_LSB = 8;
  // control register bits
  localparam int CTRL_RST_EN = 0;
  localparam int CTRL_RST_PAT = 1;
  localparam int CTRL_DLY_EN = 2;
  // detector settings bits
  localparam int DET_AND1 = 0;
  localparam int DET_AND2 = 1;
  localparam int DET_RNG1 = 2;
  localparam int DET_RNG2 = 3;
  localparam int DET_LONG1 = 4;
  localparam int DET_LONG2 = 5;
  // stage modes
  localparam logic [3:0] MODE_EDGE = 4'h0;
  localparam logic [3:0] MODE_GLITCH = 4'h1;
  localparam logic [3:0] MODE_PULSE = 4'h2;
  localparam logic [3:0] MODE_RUNT = 4'h3;
  localparam logic [3:0] MODE_SHOLD = 4'h4;
  localparam logic [3:0] MODE_STATE = 4'h5;
  localparam logic [3:0] MODE_TIMEOUT = 4'h6;
  localparam logic [3:0] MODE_TRANS = 4'h7;
  localparam logic [3:0] MODE_WINDOW = 4'h8;
  // pattern codes per channel, two bits each
  localparam logic [1:0] PAT_X = 2'h0;
  localparam logic [1:0] PAT_LOW = 2'h1;
  localparam logic [1:0] PAT_HIGH = 2'h2;
  // long timer threshold
  localparam int LONG_TIMER_NS = 30;
  localparam int CLK_MHZ = 250;
  localparam int LONG_TIMER_CYC = (LONG_TIMER_NS * CLK_MHZ) / 1000;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEQ_FIND1, SEQ_DELAY, SEQ_FIND2} sts_state_t;
endpackage : sts_pkg

/* File: src/sts_sequencer.sv */
module sts_sequencer #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // stage detectors and channel levels
  input wire logic first_stage_event_i,
  input wire logic second_stage_event_i,
  input wire logic [NCH-1:0] chan_level_i,
  // detector routing and trigger
  output logic long_timer_stage_two_o,
  output logic range_qual_stage_two_o,
  output logic trigger_o
);
  // the pattern register holds exactly four two-bit channel codes
  if (NCH != 4) begin : g_bad_nch
    $error("sts_sequencer: NCH must be 4");
  end

  // registers
  logic [3:0] mode1_reg, mode2_reg;
  logic rst_en_reg, rst_pat_reg, dly_en_reg;
  logic [7:0] pat_reg;
  logic [31:0] rtime_reg, dtime_reg;
  logic [5:0] det_reg;
  logic [1:0] aborts_reg;
  sts_pkg::sts_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic trig_reg;
  logic [1:0] ev_s1_reg, ev_s2_reg;
  logic [NCH-1:0] ch_s1_reg, ch_s2_reg;
  logic aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // input synchronisers: stage one only feeds stage two
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ev_s1_reg <= 2'h0;
      ev_s2_reg <= 2'h0;
      ch_s1_reg <= '0;
      ch_s2_reg <= '0;
    end else if (ce_i) begin
      ev_s1_reg <= {second_stage_event_i, first_stage_event_i};
      ev_s2_reg <= ev_s1_reg;
      ch_s1_reg <= chan_level_i;
      ch_s2_reg <= ch_s1_reg;
    end
  end

  wire ev1 = ev_s2_reg[0];
  wire ev2 = ev_s2_reg[1];

  // mode legality: only the nine listed codes are stored
  // edge-then-edge, video and alternating edge have no code at all
  wire [3:0] wmode1 = w_data_reg[sts_pkg::MODE1_LSB +: 4];
  wire [3:0] wmode2 = w_data_reg[sts_pkg::MODE2_LSB +: 4];
  wire mode1_ok = wmode1 <= sts_pkg::MODE_WINDOW;
  wire mode2_ok = wmode2 <= sts_pkg::MODE_WINDOW;

  // per channel pattern match, don't care always matches
  wire [NCH-1:0] ch_match;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_pat
      wire [1:0] code = pat_reg[2*g +: 2];
      assign ch_match[g] = (code == sts_pkg::PAT_HIGH) ? ch_s2_reg[g] :
                           (code == sts_pkg::PAT_LOW) ? !ch_s2_reg[g] :
                           1'b1;
    end
  endgenerate
  wire pat_hit = &ch_match;

  // detector settings sanitising: shared resources go to one stage
  wire [5:0] wdet = w_data_reg[5:0];
  wire and1_ok = !rst_en_reg;
  wire and_ok = !(rst_en_reg && rst_pat_reg);
  wire [5:0] det_clean;
  assign det_clean[sts_pkg::DET_AND1] =
    wdet[sts_pkg::DET_AND1] && and1_ok && and_ok;
  assign det_clean[sts_pkg::DET_AND2] = wdet[sts_pkg::DET_AND2] && and_ok;
  assign det_clean[sts_pkg::DET_RNG1] = wdet[sts_pkg::DET_RNG1];
  // stage one keeps the range qualifier if both ask for it
  assign det_clean[sts_pkg::DET_RNG2] =
    wdet[sts_pkg::DET_RNG2] && !wdet[sts_pkg::DET_RNG1];
  assign det_clean[sts_pkg::DET_LONG1] = wdet[sts_pkg::DET_LONG1];
  // stage two gets the long timer only when the same write does not ask for it on stage one
  assign det_clean[sts_pkg::DET_LONG2] =
    wdet[sts_pkg::DET_LONG2] && !wdet[sts_pkg::DET_LONG1];

  // resource routing to the detector bank
  assign long_timer_stage_two_o = det_reg[sts_pkg::DET_LONG2];
  assign range_qual_stage_two_o = det_reg[sts_pkg::DET_RNG2];

  // write channel handshake, address and data taken in either order
  wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  assign s_axi_awready_o = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  wire wsel_mode = aw_addr_reg == sts_pkg::OFF_MODE;
  wire wsel_ctrl = aw_addr_reg == sts_pkg::OFF_CTRL;
  wire wsel_pat = aw_addr_reg == sts_pkg::OFF_PAT;
  wire wsel_rtime = aw_addr_reg == sts_pkg::OFF_RTIME;
  wire wsel_dtime = aw_addr_reg == sts_pkg::OFF_DTIME;
  wire wsel_det = aw_addr_reg == sts_pkg::OFF_DET;
  wire wsel_stat = aw_addr_reg == sts_pkg::OFF_STAT;
  wire wmapped = wsel_mode || wsel_ctrl || wsel_pat || wsel_rtime ||
                 wsel_dtime || wsel_det || wsel_stat;

  // byte lane merge for the wide time registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  logic [3:0] w_strb_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= sts_pkg::RST_ZERO;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= sts_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wmapped ? sts_pkg::RESP_OKAY : sts_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // configuration registers; illegal modes leave the old value
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode1_reg <= sts_pkg::MODE_EDGE;
      mode2_reg <= sts_pkg::MODE_EDGE;
      rst_en_reg <= 1'b0;
      rst_pat_reg <= 1'b0;
      dly_en_reg <= 1'b0;
      pat_reg <= 8'h00;
      rtime_reg <= sts_pkg::RST_ZERO;
      dtime_reg <= sts_pkg::RST_ZERO;
      det_reg <= 6'h00;
    end else if (ce_i && do_write) begin
      if (wsel_mode && w_strb_reg[0] && mode1_ok) begin
        mode1_reg <= wmode1;
      end
      if (wsel_mode && w_strb_reg[1] && mode2_ok) begin
        mode2_reg <= wmode2;
      end
      if (wsel_ctrl && w_strb_reg[0]) begin
        rst_en_reg <= w_data_reg[sts_pkg::CTRL_RST_EN];
        rst_pat_reg <= w_data_reg[sts_pkg::CTRL_RST_PAT];
        dly_en_reg <= w_data_reg[sts_pkg::CTRL_DLY_EN];
      end
      if (wsel_pat && w_strb_reg[0]) begin
        pat_reg <= w_data_reg[7:0];
      end
      if (wsel_rtime) begin
        rtime_reg <= merge(rtime_reg, w_data_reg, w_strb_reg);
      end
      if (wsel_dtime) begin
        dtime_reg <= merge(dtime_reg, w_data_reg, w_strb_reg);
      end
      if (wsel_det && w_strb_reg[0]) begin
        det_reg <= det_clean;
      end
    end
  end

  // sequencer next state and shared counter
  wire rst_time = rst_en_reg && !rst_pat_reg;
  wire rst_pat = rst_en_reg && rst_pat_reg && pat_hit;
  wire time_out = rst_time && (cnt_reg >= rtime_reg);
  logic abort_pulse;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    abort_pulse = 1'b0;
    case (state_reg)
      sts_pkg::SEQ_FIND1: begin
        cnt_next = sts_pkg::RST_ZERO;
        if (ev1) begin
          state_next = dly_en_reg ? sts_pkg::SEQ_DELAY :
                       sts_pkg::SEQ_FIND2;
        end
      end
      sts_pkg::SEQ_DELAY: begin
        cnt_next = cnt_reg + 32'h1;
        if (rst_pat) begin
          state_next = sts_pkg::SEQ_FIND1;
          abort_pulse = 1'b1;
        end else if (cnt_reg + 32'h1 >= dtime_reg) begin
          state_next = sts_pkg::SEQ_FIND2;
          cnt_next = sts_pkg::RST_ZERO;
        end
      end
      sts_pkg::SEQ_FIND2: begin
        cnt_next = cnt_reg + 32'h1;
        if (ev2) begin
          state_next = sts_pkg::SEQ_FIND1;
        end else if (rst_pat || time_out) begin
          state_next = sts_pkg::SEQ_FIND1;
          abort_pulse = 1'b1;
        end
        // with reset off neither abort term can fire
      end
      default: state_next = sts_pkg::SEQ_FIND1;
    endcase
  end

  wire fire = (state_reg == sts_pkg::SEQ_FIND2) && ev2;

  // sequencer state; trigger is a one cycle registered pulse
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= sts_pkg::SEQ_FIND1;
      cnt_reg <= sts_pkg::RST_ZERO;
      trig_reg <= 1'b0;
      aborts_reg <= 2'h0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      trig_reg <= fire;
      if (abort_pulse) aborts_reg <= aborts_reg + 2'h1;
    end
  end
  assign trigger_o = trig_reg;

  // read channel: one cycle after arvalid, held until rready
  wire [7:0] ra = {s_axi_araddr_i[7:2], 2'b00};
  wire [31:0] rd_mode = {20'h0, mode2_reg, 4'h0, mode1_reg};
  wire [31:0] rd_ctrl = {29'h0, dly_en_reg, rst_pat_reg, rst_en_reg};
  wire [31:0] rd_stat = {26'h0, aborts_reg, 2'h0, state_reg};
  wire rmapped = ra <= sts_pkg::OFF_STAT;
  wire [31:0] rd_val =
    (ra == sts_pkg::OFF_MODE) ? rd_mode :
    (ra == sts_pkg::OFF_CTRL) ? rd_ctrl :
    (ra == sts_pkg::OFF_PAT) ? {24'h0, pat_reg} :
    (ra == sts_pkg::OFF_RTIME) ? rtime_reg :
    (ra == sts_pkg::OFF_DTIME) ? dtime_reg :
    (ra == sts_pkg::OFF_DET) ? {26'h0, det_reg} :
    (ra == sts_pkg::OFF_STAT) ? rd_stat : sts_pkg::RST_ZERO;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= sts_pkg::RST_ZERO;
      rresp_reg <= sts_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_val;
        rresp_reg <= rmapped ? sts_pkg::RESP_OKAY : sts_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
endmodule : sts_sequencer
